// File: updown_counter_cfg.svh
`ifndef UPDOWN_COUNTER_CFG_SVH
`define UPDOWN_COUNTER_CFG_SVH

// Width of the count.
`define CNT_WIDTH       4
// Count value held after the sync reset and after a clear.
`define CNT_CLEAR_VALUE 4'h0
// Idle level of both count clocks and of the terminal outputs.
`define CLK_IDLE_LEVEL  1'b1
`define TERM_IDLE_LEVEL 1'b1

`endif

// File: updown_counter_pkg.sv
package updown_counter_pkg;

    // Control levels driven by the outside party, sampled on clk_sys_i.
    typedef struct packed {
        logic count_up_clock;
        logic count_down_clock;
        logic master_clear;
        logic preset_load_n;
    } counter_ctrl_t;

    // Active-low terminal outputs used to clock the next stage.
    typedef struct packed {
        logic carry_out_n;
        logic borrow_out_n;
    } counter_term_t;

endpackage

// File: presettable_updown_counter4.sv
`timescale 1ns/1ps
`include "updown_counter_cfg.svh"
// Notes on behaviour
// - A rising edge on the up clock while the down clock is high and not itself rising adds one to the count.
// - A rising edge on the down clock while the up clock is high and not itself rising subtracts one from the count.
// - The count changes only on a rising count clock edge, apart from clear and preset.
// - A high master clear forces the count to zero without any count clock edge.
// - Clear overrides preset, both count clocks and the preset data.
// - A low preset load without clear copies the preset value into the count regardless of the clocks.
// - Carry and borrow stay high while their terminal condition is not met.
// - At count fifteen the carry output follows the up clock, low during its low phase.
// - At count zero the borrow output follows the down clock, low during its low phase.
// - A clock held low through a clear or preset counts on its next rising edge.
// - The count is a four-bit unsigned binary value counting either way.
// - Up from fifteen wraps to zero and down from zero wraps to fifteen.
// - Carry and borrow can clock the up and down inputs of the next stage directly.
module presettable_updown_counter4 #(
    parameter int WIDTH = `CNT_WIDTH
) (
    input  wire logic                              clk_sys_i,
    input  wire logic                              srst_i,
    input  wire updown_counter_pkg::counter_ctrl_t ctrl_i,
    input  wire logic [WIDTH-1:0]                  preset_value_i,
    output logic      [WIDTH-1:0]                  count_value_o,
    output updown_counter_pkg::counter_term_t      term_o
);

    localparam logic [WIDTH-1:0] CNT_MAX   = '1;
    localparam logic [WIDTH-1:0] CNT_CLEAR = WIDTH'(`CNT_CLEAR_VALUE);

    // Terminal decode, shared by the carry and borrow paths.
    function automatic logic at_value(input logic [WIDTH-1:0] cnt, input logic [WIDTH-1:0] ref_val);
        at_value = (cnt == ref_val);
    endfunction

    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;
    logic             up_prev_q;
    logic             down_prev_q;
    logic             up_rise;
    logic             down_rise;
    logic             step_up;
    logic             step_down;
    logic             carry_n_d;
    logic             borrow_n_d;
    updown_counter_pkg::counter_term_t term_q;

    // Previous levels track the clocks through clear and preset as well, so a clock
    // that stays low across them still yields a rising edge afterwards.
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            up_prev_q   <= `CLK_IDLE_LEVEL;
            down_prev_q <= `CLK_IDLE_LEVEL;
        end else begin
            up_prev_q   <= ctrl_i.count_up_clock;
            down_prev_q <= ctrl_i.count_down_clock;
        end
    end

    assign up_rise   = ctrl_i.count_up_clock & ~up_prev_q;
    assign down_rise = ctrl_i.count_down_clock & ~down_prev_q;
    // Simultaneous rises on both clocks break the idle-high discipline of the driver,
    // so neither is counted rather than picking one arbitrarily.
    assign step_up   = up_rise & ctrl_i.count_down_clock & ~down_rise;
    assign step_down = down_rise & ctrl_i.count_up_clock & ~up_rise;

    always_comb begin
        count_d = count_q;
        if (ctrl_i.master_clear) begin
            count_d = CNT_CLEAR;
        end else if (!ctrl_i.preset_load_n) begin
            count_d = preset_value_i;
        end else if (step_up) begin
            count_d = WIDTH'(count_q + 1'b1);
        end else if (step_down) begin
            count_d = WIDTH'(count_q - 1'b1);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            count_q <= CNT_CLEAR;
        end else begin
            count_q <= count_d;
        end
    end

    // Decoding from the next count keeps the registered terminal outputs aligned with
    // the registered count, at the cost of one cycle of lag behind the clock levels.
    assign carry_n_d  = ~(at_value(count_d, CNT_MAX) & ~ctrl_i.count_up_clock);
    assign borrow_n_d = ~(at_value(count_d, CNT_CLEAR) & ~ctrl_i.count_down_clock);

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            term_q.carry_out_n  <= `TERM_IDLE_LEVEL;
            term_q.borrow_out_n <= `TERM_IDLE_LEVEL;
        end else begin
            term_q.carry_out_n  <= carry_n_d;
            term_q.borrow_out_n <= borrow_n_d;
        end
    end

    assign count_value_o = count_q;
    assign term_o        = term_q;

    sequence seq_up_step;
        !ctrl_i.master_clear && ctrl_i.preset_load_n && step_up;
    endsequence

    sequence seq_down_step;
        !ctrl_i.master_clear && ctrl_i.preset_load_n && step_down;
    endsequence

    sequence seq_idle;
        !ctrl_i.master_clear && ctrl_i.preset_load_n && !step_up && !step_down;
    endsequence

    a_up_increment: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        seq_up_step |=> count_value_o == WIDTH'($past(count_value_o) + 1'b1)
    ) else $error("Count did not step up after an up clock edge.");

    a_down_decrement: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        seq_down_step |=> count_value_o == WIDTH'($past(count_value_o) - 1'b1)
    ) else $error("Count did not step down after a down clock edge.");

    a_hold_no_edge: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        seq_idle |=> $stable(count_value_o)
    ) else $error("Count changed without a clock edge, clear or preset.");

    a_clear_wins: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        ctrl_i.master_clear |=> count_value_o == CNT_CLEAR
    ) else $error("Count not zero after a master clear.");

    a_preset_copy: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        !ctrl_i.master_clear && !ctrl_i.preset_load_n |=> count_value_o == $past(preset_value_i)
    ) else $error("Count does not match the preset value after a load.");

    a_carry_follow: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        ##1 count_value_o == CNT_MAX |-> term_o.carry_out_n == $past(ctrl_i.count_up_clock)
    ) else $error("Carry does not follow the up clock at count fifteen.");

    a_borrow_follow: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        ##1 count_value_o == CNT_CLEAR |-> term_o.borrow_out_n == $past(ctrl_i.count_down_clock)
    ) else $error("Borrow does not follow the down clock at count zero.");

    a_term_rest_high: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        count_value_o != CNT_MAX && count_value_o != CNT_CLEAR |-> term_o.carry_out_n && term_o.borrow_out_n
    ) else $error("A terminal output is low away from its terminal count.");

    a_wrap_up: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        seq_up_step and (count_value_o == CNT_MAX) |=> count_value_o == CNT_CLEAR
    ) else $error("Count did not wrap from fifteen to zero.");

    a_relaunch_low: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        ctrl_i.master_clear && !ctrl_i.count_up_clock && ctrl_i.count_down_clock
        ##1 !ctrl_i.master_clear && ctrl_i.preset_load_n && ctrl_i.count_up_clock && ctrl_i.count_down_clock
        |=> count_value_o == WIDTH'(CNT_CLEAR + 1'b1)
    ) else $error("Rising edge after a clear was not counted.");

    // The outputs are registered, so a terminal check looks one edge after the clock
    // level that it follows, and a count check one edge after its cause.
    sequence seq_free_run;
        !ctrl_i.master_clear && ctrl_i.preset_load_n && ctrl_i.count_up_clock && ctrl_i.count_down_clock;
    endsequence

    a_wrap_down: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        seq_down_step and (count_value_o == CNT_CLEAR) |=> count_value_o == CNT_MAX
    ) else $error("Count did not wrap from zero to fifteen.");

    a_wrap_carry: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        seq_up_step and (count_value_o == CNT_MAX) |-> !term_o.carry_out_n
    ) else $error("Carry was not low ahead of the wrap to zero.");

    a_wrap_borrow: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        seq_down_step and (count_value_o == CNT_CLEAR) |-> !term_o.borrow_out_n
    ) else $error("Borrow was not low ahead of the wrap to fifteen.");

    a_carry_idle: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        ctrl_i.count_up_clock |=> term_o.carry_out_n
    ) else $error("Carry went low while the up clock was high.");

    a_borrow_idle: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        ctrl_i.count_down_clock |=> term_o.borrow_out_n
    ) else $error("Borrow went low while the down clock was high.");

    a_carry_at_max: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        !term_o.carry_out_n |-> count_value_o == CNT_MAX
    ) else $error("Carry is low away from count fifteen.");

    a_borrow_at_zero: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        !term_o.borrow_out_n |-> count_value_o == CNT_CLEAR
    ) else $error("Borrow is low away from count zero.");

    a_clear_term: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        ctrl_i.master_clear |=> term_o.carry_out_n && term_o.borrow_out_n == $past(ctrl_i.count_down_clock)
    ) else $error("Terminal outputs wrong while a clear is applied.");

    a_preset_term: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        !ctrl_i.master_clear && !ctrl_i.preset_load_n |=>
            term_o.carry_out_n == !($past(preset_value_i) == CNT_MAX && !$past(ctrl_i.count_up_clock)) &&
            term_o.borrow_out_n == !($past(preset_value_i) == CNT_CLEAR && !$past(ctrl_i.count_down_clock))
    ) else $error("Terminal outputs wrong while a preset is applied.");

    a_change_cause: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        $changed(count_value_o) |->
            $past(ctrl_i.master_clear) || !$past(ctrl_i.preset_load_n) || $past(step_up) || $past(step_down)
    ) else $error("Count changed with no clear, preset or clock edge behind it.");

    a_relaunch_down: assert property (
        @(posedge clk_sys_i) disable iff (srst_i)
        ctrl_i.master_clear && ctrl_i.count_up_clock && !ctrl_i.count_down_clock
        ##1 seq_free_run
        |=> count_value_o == CNT_MAX
    ) else $error("Down edge after a clear was not counted.");

endmodule

// File: clock_pulse_driver.sv
`timescale 1ns/1ps
module clock_pulse_driver (
    input  wire logic clk_sys_i,
    input  wire logic srst_i,
    input  wire logic up_low_i,
    input  wire logic dn_low_i,
    output logic      up_clk_o,
    output logic      dn_clk_o
);
    // A request for both clocks low at once is dropped, so the idle clock always stays high.
    always_ff @(posedge clk_sys_i) begin
        up_clk_o <= srst_i | !(up_low_i & !dn_low_i);
        dn_clk_o <= srst_i | !(dn_low_i & !up_low_i);
    end
endmodule

// File: tb_presettable_updown_counter4.sv
`timescale 1ns/1ps
module tb_presettable_updown_counter4;
    logic                              clk_sys_i = 1'b0;
    logic                              srst_i    = 1'b1;
    logic                              up_low    = 1'b0;
    logic                              dn_low    = 1'b0;
    logic                              clr       = 1'b0;
    logic                              load_n    = 1'b1;
    logic [3:0]                        pv        = 4'h0;
    logic                              up_clk;
    logic                              dn_clk;
    logic [3:0]                        cnt;
    updown_counter_pkg::counter_ctrl_t ctrl;
    updown_counter_pkg::counter_term_t term;
    updown_counter_pkg::counter_term_t mid;
    int                                n_fail    = 0;
    int                                compares  = 0;
    int                                cycles    = 0;

    initial forever #5 clk_sys_i = ~clk_sys_i;
    assign ctrl = {up_clk, dn_clk, clr, load_n};

    clock_pulse_driver drv (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .up_low_i(up_low), .dn_low_i(dn_low),
                            .up_clk_o(up_clk), .dn_clk_o(dn_clk));
    presettable_updown_counter4 dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .ctrl_i(ctrl),
                                     .preset_value_i(pv), .count_value_o(cnt), .term_o(term));

    task automatic final_report;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk_cnt(input logic [3:0] exp);
        compares++;
        if (cnt !== exp) begin
            n_fail++;
            $display("wrong value count expected %h seen %h", exp, cnt);
        end
    endtask

    task automatic chk_term(input updown_counter_pkg::counter_term_t exp, input updown_counter_pkg::counter_term_t got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value terminal expected %b seen %b", exp, got);
        end
    endtask

    // Terminal outputs lag the clock by one cycle, so mid is taken in the low phase as the design saw it.
    task automatic step(input logic up);
        @(posedge clk_sys_i);
        up_low <= up;
        dn_low <= !up;
        @(posedge clk_sys_i);
        up_low <= 1'b0;
        dn_low <= 1'b0;
        @(posedge clk_sys_i);
        #1 mid = term;
        @(posedge clk_sys_i);
        #1;
    endtask

    task automatic load(input logic c, input logic [3:0] v);
        @(posedge clk_sys_i);
        clr <= c;
        load_n <= 1'b0;
        pv <= v;
        @(posedge clk_sys_i);
        clr <= 1'b0;
        load_n <= 1'b1;
        @(posedge clk_sys_i);
        #1;
    endtask

    // One clock is low when the clear is sampled and rises on the very next edge.
    task automatic clr_held(input logic up);
        @(posedge clk_sys_i);
        up_low <= up;
        dn_low <= !up;
        @(posedge clk_sys_i);
        up_low <= 1'b0;
        dn_low <= 1'b0;
        clr <= 1'b1;
        @(posedge clk_sys_i);
        clr <= 1'b0;
        #1 mid = term;
        @(posedge clk_sys_i);
        #1;
    endtask

    task automatic t_counts;
        load(1'b0, 4'hd);
        chk_cnt(4'hd);
        for (int i = 0; i < 5; i++) begin
            step(1'b1);
            chk_cnt(4'he + i[3:0]);
            chk_term(i == 2 ? 2'b01 : 2'b11, mid);
        end
        for (int i = 0; i < 5; i++) begin
            step(1'b0);
            chk_cnt(4'h1 - i[3:0]);
            chk_term(i == 2 ? 2'b10 : 2'b11, mid);
        end
        $display("test counts done");
    endtask

    task automatic t_clear;
        load(1'b1, 4'h5);
        chk_cnt(4'h0);
        chk_term(2'b11, term);
        clr_held(1'b1);
        chk_term(2'b11, mid);
        chk_cnt(4'h1);
        clr_held(1'b0);
        chk_term(2'b10, mid);
        chk_cnt(4'hf);
        $display("test clear done");
    endtask

    task automatic t_held;
        @(posedge clk_sys_i);
        up_low <= 1'b1;
        load(1'b0, 4'h7);
        chk_cnt(4'h7);
        @(posedge clk_sys_i);
        up_low <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        #1 chk_cnt(4'h8);
        repeat (4) @(posedge clk_sys_i);
        #1 chk_cnt(4'h8);
        $display("test held clock done");
    endtask

    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 500) begin
            n_fail++;
            final_report;
        end
    end

    initial begin
        repeat (3) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        #1 chk_cnt(4'h0);
        chk_term(2'b11, term);
        t_counts;
        t_clear;
        t_held;
        final_report;
    end
endmodule
